// [emb_page_pkg.sv]
// Notes on behaviour
// R1: Learning-core events one to four show in status bits 0 to 3; bits 4 to 7 read zero.
// R2: Latch-mode bit 1 latches embedded-function interrupt requests, 0 does not; resets to 0.
// R3: Advanced-page writes are accepted only while page-write enable is 1; resets to 0.
// R4: Advanced-page reads return data only while page-read enable is 1; resets to 0.
// R5: The advanced page is chosen by a four-bit select field at offset 02h.
// R6: Learning-core results are batched into the FIFO while their enable is 1; resets 0.
// R7: Step counter values are batched into the FIFO while their enable is 1; resets 0.
// R8: Fusion gyroscope bias values are batched while their enable is 1; resets 0.
// R9: Fusion gravity values are batched while their enable is 1; resets 0.
// R10: Fusion quaternion values are batched while their enable is 1; resets 0.
// R11: Bit 6 of batch register B batches learning-core filters and features; resets 0.
// R12: Each of eight state machines runs only while its enable bit is 1; all reset 0.
// R13: Long counter is 16-bit unsigned, low byte at 48h, high byte at 49h.
// R14: Long counter bytes show the current value, are read/write and reset to zero.
// R15: In latched mode a read leaves status bit n alone when keep-mask bit n is 1.
// R16: In latched mode a read clears status bit n when keep-mask bit n is 0; mask resets 0.
// R17: The keep mask covers the three status registers and mirrors at 49h, 4Ah, 4Bh.
// R18: Machine one outputs flag +X,-X,+Y,-Y,+Z,-Z,+V,-V from bit 7 down to 0.
// R19: The host writes zero to reserved bits of page-access and batch registers.
// R20: Latched status stays set until a read clears it; otherwise it follows the event.
package emb_page_pkg;

  // Embedded page offsets
  localparam logic [7:0] OFF_PAGE_SELECT = 8'h02;
  localparam logic [7:0] OFF_ADV_ADDRESS = 8'h08;
  localparam logic [7:0] OFF_ADV_DATA = 8'h09;
  localparam logic [7:0] OFF_EMBEDDED_STATUS = 8'h12;
  localparam logic [7:0] OFF_MACHINE_STATUS = 8'h13;
  localparam logic [7:0] OFF_LEARN_STATUS = 8'h15;
  localparam logic [7:0] OFF_PAGE_ACCESS = 8'h17;
  localparam logic [7:0] OFF_BATCH_A = 8'h44;
  localparam logic [7:0] OFF_BATCH_B = 8'h45;
  localparam logic [7:0] OFF_MACHINE_ENABLES = 8'h46;
  localparam logic [7:0] OFF_LONG_COUNT_LOW = 8'h48;
  localparam logic [7:0] OFF_LONG_COUNT_HIGH = 8'h49;
  localparam logic [7:0] OFF_ACK_KEEP_MASK = 8'h4b;
  localparam logic [7:0] OFF_MACHINE_ONE_OUTS = 8'h4c;

  // Main page mirror offsets
  localparam logic [7:0] OFF_EMBEDDED_MIRROR = 8'h49;
  localparam logic [7:0] OFF_MACHINE_MIRROR = 8'h4a;
  localparam logic [7:0] OFF_LEARN_MIRROR = 8'h4b;

  // Page access field positions
  localparam int POS_LATCH_MODE = 7;
  localparam int POS_PAGE_WRITE = 6;
  localparam int POS_PAGE_READ = 5;

  // Batch register A and B field positions
  localparam int POS_LEARN_RESULT_BATCH = 7;
  localparam int POS_STEP_COUNT_BATCH = 6;
  localparam int POS_GYRO_BIAS_BATCH = 5;
  localparam int POS_GRAVITY_BATCH = 4;
  localparam int POS_QUATERNION_BATCH = 1;
  localparam int POS_LEARN_FEATURE_BATCH = 6;

  // Writable bit masks; reserved bits are dropped on write and read as zero
  localparam logic [7:0] MASK_PAGE_SELECT = 8'h0f;
  localparam logic [7:0] MASK_PAGE_ACCESS = 8'he0;
  localparam logic [7:0] MASK_BATCH_A = 8'hf2;
  localparam logic [7:0] MASK_BATCH_B = 8'h40;

  // Status bits that can ever be set
  localparam logic [7:0] LIVE_EMBEDDED_STATUS = 8'hb8;
  localparam logic [7:0] LIVE_MACHINE_STATUS = 8'hff;
  localparam logic [7:0] LIVE_LEARN_STATUS = 8'h0f;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_LONG_COUNT = 16'h0000;

endpackage

// [event_status_bits.sv]
`timescale 1ns/10ps
`default_nettype none
module event_status_bits
  import emb_page_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [7:0] LIVE = 8'hff
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] event_i,
  input wire logic latch_i,
  input wire logic clear_i,
  input wire logic [WIDTH-1:0] keep_i,
  output logic [WIDTH-1:0] status_o
);

  logic [WIDTH-1:0] status_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Per-bit next state; a new event beats a read clear in the same cycle
  generate
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      if (LIVE[b]) begin : g_live
        assign status_nxt[b] = latch_i ?
          (event_i[b] | (status_o[b] & ~(clear_i & ~keep_i[b]))) : // see R15 see R16 see R20
          event_i[b]; // see R20
      end else begin : g_dead
        assign status_nxt[b] = 1'b0; // see R1
      end
    end
  endgenerate

  // Status flops
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_o <= '0;
    end else begin
      status_o <= status_nxt;
    end
  end

endmodule
`default_nettype wire

// [emb_page_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module emb_page_regs
  import emb_page_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic main_page_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [7:0] emb_event_i,
  input wire logic [7:0] machine_event_i,
  input wire logic [3:0] learn_event_i,
  input wire logic long_count_tick_i,
  input wire logic [7:0] machine1_out_i,
  input wire logic [7:0] adv_rdata_i,
  output logic latch_mode_o,
  output logic [3:0] adv_page_sel_o,
  output logic [7:0] adv_addr_o,
  output logic [7:0] adv_wdata_o,
  output logic adv_wr_o,
  output logic adv_rd_o,
  output logic learn_result_batch_en_o,
  output logic step_count_batch_en_o,
  output logic gyro_bias_batch_en_o,
  output logic gravity_batch_en_o,
  output logic quaternion_batch_en_o,
  output logic learn_feature_batch_en_o,
  output logic [7:0] machine_enable_o,
  output logic [15:0] long_count_value_o,
  output logic [7:0] machine1_outs_o
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  ////////////////////////////////////////////////////////////////////////
  // Address decode; the main page only exposes the three status mirrors
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off, input logic page);
    hit = (addr == off) && page;
  endfunction

  logic emb_page;
  logic sel_page_select;
  logic sel_adv_address;
  logic sel_adv_data;
  logic sel_emb_status;
  logic sel_mach_status;
  logic sel_learn_status;
  logic sel_page_access;
  logic sel_batch_a;
  logic sel_batch_b;
  logic sel_mach_enables;
  logic sel_count_low;
  logic sel_count_high;
  logic sel_ack_mask;
  logic sel_mach_outs;
  logic sel_any;

  assign emb_page = !main_page_i;
  assign sel_page_select = hit(reg_addr_i, OFF_PAGE_SELECT, emb_page);
  assign sel_adv_address = hit(reg_addr_i, OFF_ADV_ADDRESS, emb_page);
  assign sel_adv_data = hit(reg_addr_i, OFF_ADV_DATA, emb_page);
  // Status registers and their mirrors share one clear path
  assign sel_emb_status = hit(reg_addr_i, OFF_EMBEDDED_STATUS, emb_page) ||
                          hit(reg_addr_i, OFF_EMBEDDED_MIRROR, main_page_i); // see R17
  assign sel_mach_status = hit(reg_addr_i, OFF_MACHINE_STATUS, emb_page) ||
                           hit(reg_addr_i, OFF_MACHINE_MIRROR, main_page_i); // see R17
  assign sel_learn_status = hit(reg_addr_i, OFF_LEARN_STATUS, emb_page) ||
                            hit(reg_addr_i, OFF_LEARN_MIRROR, main_page_i); // see R17
  assign sel_page_access = hit(reg_addr_i, OFF_PAGE_ACCESS, emb_page);
  assign sel_batch_a = hit(reg_addr_i, OFF_BATCH_A, emb_page);
  assign sel_batch_b = hit(reg_addr_i, OFF_BATCH_B, emb_page);
  assign sel_mach_enables = hit(reg_addr_i, OFF_MACHINE_ENABLES, emb_page);
  assign sel_count_low = hit(reg_addr_i, OFF_LONG_COUNT_LOW, emb_page); // see R13
  assign sel_count_high = hit(reg_addr_i, OFF_LONG_COUNT_HIGH, emb_page); // see R13
  assign sel_ack_mask = hit(reg_addr_i, OFF_ACK_KEEP_MASK, emb_page);
  assign sel_mach_outs = hit(reg_addr_i, OFF_MACHINE_ONE_OUTS, emb_page);
  assign sel_any = sel_page_select | sel_adv_address | sel_adv_data | sel_emb_status |
                   sel_mach_status | sel_learn_status | sel_page_access | sel_batch_a |
                   sel_batch_b | sel_mach_enables | sel_count_low | sel_count_high |
                   sel_ack_mask | sel_mach_outs;

  ////////////////////////////////////////////////////////////////////////
  // Software-written control registers
  logic [7:0] page_select_r;
  logic [7:0] adv_address_r;
  logic [7:0] page_access_r;
  logic [7:0] batch_a_r;
  logic [7:0] batch_b_r;
  logic [7:0] mach_enables_r;
  logic [7:0] ack_keep_r;
  logic latch_mode;
  logic page_write_en;
  logic page_read_en;

  assign latch_mode = page_access_r[POS_LATCH_MODE]; // see R2
  assign page_write_en = page_access_r[POS_PAGE_WRITE];
  assign page_read_en = page_access_r[POS_PAGE_READ];

  // Reserved bits are masked so they always read back as zero
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      page_select_r <= RST_BYTE;
      adv_address_r <= RST_BYTE;
      page_access_r <= RST_BYTE; // see R2 see R3 see R4
      batch_a_r <= RST_BYTE; // see R6 see R7 see R8 see R9 see R10
      batch_b_r <= RST_BYTE; // see R11
      mach_enables_r <= RST_BYTE; // see R12
      ack_keep_r <= RST_BYTE; // see R16
    end else if (reg_wr_i) begin
      if (sel_page_select) page_select_r <= reg_wdata_i & MASK_PAGE_SELECT; // see R5
      if (sel_adv_address) adv_address_r <= reg_wdata_i;
      if (sel_page_access) page_access_r <= reg_wdata_i & MASK_PAGE_ACCESS; // see R19
      if (sel_batch_a) batch_a_r <= reg_wdata_i & MASK_BATCH_A; // see R19
      if (sel_batch_b) batch_b_r <= reg_wdata_i & MASK_BATCH_B; // see R19
      if (sel_mach_enables) mach_enables_r <= reg_wdata_i; // see R12
      if (sel_ack_mask) ack_keep_r <= reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Long counter: host write of a byte wins over a tick in that cycle
  logic [15:0] long_count_r;
  logic [15:0] long_count_nxt;

  assign long_count_nxt = (reg_wr_i && sel_count_low) ? {long_count_r[15:8], reg_wdata_i} :
                          (reg_wr_i && sel_count_high) ? {reg_wdata_i, long_count_r[7:0]} :
                          long_count_tick_i ? long_count_r + 16'h0001 :
                          long_count_r; // see R14

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      long_count_r <= RST_LONG_COUNT; // see R14
    end else begin
      long_count_r <= long_count_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Machine one outputs, sampled each cycle so reads see a stable byte
  logic [7:0] mach_outs_r;

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mach_outs_r <= RST_BYTE;
    end else begin
      mach_outs_r <= machine1_out_i; // see R18
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status registers; a read in latched mode clears the bits not kept
  logic emb_clear;
  logic mach_clear;
  logic learn_clear;
  logic [7:0] emb_status;
  logic [7:0] mach_status;
  logic [3:0] learn_status;

  assign emb_clear = reg_rd_i && sel_emb_status;
  assign mach_clear = reg_rd_i && sel_mach_status;
  assign learn_clear = reg_rd_i && sel_learn_status;

  event_status_bits #(.WIDTH(8), .LIVE(LIVE_EMBEDDED_STATUS)) u_emb_status (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .event_i(emb_event_i),
    .latch_i(latch_mode),
    .clear_i(emb_clear),
    .keep_i(ack_keep_r),
    .status_o(emb_status)
  );

  event_status_bits #(.WIDTH(8), .LIVE(LIVE_MACHINE_STATUS)) u_mach_status (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .event_i(machine_event_i),
    .latch_i(latch_mode),
    .clear_i(mach_clear),
    .keep_i(ack_keep_r),
    .status_o(mach_status)
  );

  event_status_bits #(.WIDTH(4), .LIVE(LIVE_LEARN_STATUS)) u_learn_status (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .event_i(learn_event_i), // see R1
    .latch_i(latch_mode),
    .clear_i(learn_clear),
    .keep_i(ack_keep_r[3:0]),
    .status_o(learn_status)
  );

  ////////////////////////////////////////////////////////////////////////
  // Advanced page window; gated by the page access enables
  logic adv_wr_nxt;
  logic adv_rd_nxt;

  assign adv_wr_nxt = reg_wr_i && sel_adv_data && page_write_en; // see R3
  assign adv_rd_nxt = reg_rd_i && sel_adv_data && page_read_en; // see R4

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      adv_wr_o <= 1'b0;
      adv_rd_o <= 1'b0;
      adv_wdata_o <= RST_BYTE;
    end else begin
      adv_wr_o <= adv_wr_nxt;
      adv_rd_o <= adv_rd_nxt;
      if (adv_wr_nxt) adv_wdata_o <= reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses and a blocked page read return zero
  logic [7:0] rdata_nxt;

  assign rdata_nxt = sel_page_select ? page_select_r :
                     sel_adv_address ? adv_address_r :
                     adv_rd_nxt ? adv_rdata_i : // see R4
                     sel_emb_status ? emb_status :
                     sel_mach_status ? mach_status :
                     sel_learn_status ? {4'h0, learn_status} : // see R1
                     sel_page_access ? page_access_r :
                     sel_batch_a ? batch_a_r :
                     sel_batch_b ? batch_b_r :
                     sel_mach_enables ? mach_enables_r :
                     sel_count_low ? long_count_r[7:0] :
                     sel_count_high ? long_count_r[15:8] :
                     sel_ack_mask ? ack_keep_r :
                     sel_mach_outs ? mach_outs_r : // see R18
                     8'h00;

  // Read data holds for exactly the cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= RST_BYTE;
    end else begin
      reg_rdata_o <= (reg_rd_i && sel_any) ? rdata_nxt : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output copies of the control state, all taken straight from flops
  assign latch_mode_o = page_access_r[POS_LATCH_MODE];
  assign adv_page_sel_o = page_select_r[3:0]; // see R5
  assign adv_addr_o = adv_address_r;
  assign learn_result_batch_en_o = batch_a_r[POS_LEARN_RESULT_BATCH]; // see R6
  assign step_count_batch_en_o = batch_a_r[POS_STEP_COUNT_BATCH]; // see R7
  assign gyro_bias_batch_en_o = batch_a_r[POS_GYRO_BIAS_BATCH]; // see R8
  assign gravity_batch_en_o = batch_a_r[POS_GRAVITY_BATCH]; // see R9
  assign quaternion_batch_en_o = batch_a_r[POS_QUATERNION_BATCH]; // see R10
  assign learn_feature_batch_en_o = batch_b_r[POS_LEARN_FEATURE_BATCH]; // see R11
  assign machine_enable_o = mach_enables_r; // see R12
  assign long_count_value_o = long_count_r; // see R13
  assign machine1_outs_o = mach_outs_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  a_latch_hold: assert property ( // see R20
    (latch_mode && learn_status[0] && !learn_clear) |=> learn_status[0])
    else $error("latched status bit dropped without a read");

  a_read_clears: assert property ( // see R16
    (latch_mode && learn_clear && !ack_keep_r[0] && !learn_event_i[0]) |=> !learn_status[0])
    else $error("unmasked status bit not cleared by read");

  a_read_keeps: assert property ( // see R15
    (latch_mode && learn_clear && ack_keep_r[0] && learn_status[0]) |=> learn_status[0])
    else $error("masked status bit cleared by read");

  a_follow_event: assert property ( // see R20
    (!latch_mode && $stable(latch_mode)) |=> (learn_status == $past(learn_event_i)))
    else $error("non-latched status does not follow event");

  a_upper_zero: assert property ( // see R1
    (reg_rd_i && sel_learn_status) |=> (reg_rdata_o[7:4] == 4'h0))
    else $error("learning status upper bits not zero");

  a_page_wr_gate: assert property ( // see R3
    adv_wr_o |-> $past(page_write_en) && $past(reg_wr_i))
    else $error("page write issued while disabled");

  a_page_rd_gate: assert property ( // see R4
    (reg_rd_i && sel_adv_data && !page_read_en) |=> (reg_rdata_o == 8'h00) && !adv_rd_o)
    else $error("page read returned data while disabled");

  a_count_write: assert property ( // see R14
    (reg_wr_i && sel_count_low) |=> (long_count_value_o[7:0] == $past(reg_wdata_i)))
    else $error("long counter low byte write lost");

  a_count_tick: assert property ( // see R14
    (long_count_tick_i && !(reg_wr_i && (sel_count_low || sel_count_high)))
      |=> (long_count_value_o == 16'($past(long_count_value_o) + 16'h0001)))
    else $error("long counter did not advance");

  a_machine_en: assert property ( // see R12
    (reg_wr_i && sel_mach_enables) |=> (machine_enable_o == $past(reg_wdata_i)))
    else $error("machine enables not updated");

  a_mirror_clear: assert property ( // see R16 see R17
    (latch_mode && mach_clear && !ack_keep_r[7] && !machine_event_i[7]) |=> !mach_status[7])
    else $error("machine status bit not cleared by read");

  a_emb_clear: assert property ( // see R16 see R17
    (latch_mode && emb_clear && !ack_keep_r[7] && !emb_event_i[7]) |=> !emb_status[7])
    else $error("embedded status bit not cleared by read");

  a_count_read: assert property ( // see R13
    (reg_rd_i && sel_count_high) |=> (reg_rdata_o == $past(long_count_r[15:8])))
    else $error("long counter high byte read wrong");

  a_page_select: assert property ( // see R5
    (reg_wr_i && sel_page_select) |=> (adv_page_sel_o == $past(reg_wdata_i[3:0])))
    else $error("page select not updated");

  a_latch_write: assert property ( // see R2
    (reg_wr_i && sel_page_access) |=> (latch_mode_o == $past(reg_wdata_i[POS_LATCH_MODE])))
    else $error("latch mode bit not updated");

  a_feature_batch: assert property ( // see R11
    (reg_wr_i && sel_batch_b) |=> (learn_feature_batch_en_o == $past(reg_wdata_i[POS_LEARN_FEATURE_BATCH])))
    else $error("feature batch enable not updated");

  a_outs_track: assert property ( // see R18
    rst_n |=> (machine1_outs_o == $past(machine1_out_i)))
    else $error("machine one outputs not sampled");

  c_latched_clear: cover property (latch_mode && learn_clear && learn_status != 4'h0);
  c_page_write: cover property (adv_wr_o);
  c_mirror_read: cover property (reg_rd_i && main_page_i && sel_emb_status);
  c_count_wrap: cover property (long_count_tick_i && long_count_r == 16'hffff);

endmodule
`default_nettype wire

// [emb_page_regs_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module emb_page_regs_tb
  import emb_page_pkg::*;
;
  logic sys_clk_i, rst_n_i, main_page_i, reg_wr_i, reg_rd_i, long_count_tick_i;
  logic [7:0] reg_addr_i, reg_wdata_i, emb_event_i, machine_event_i, machine1_out_i, adv_rdata_i;
  logic [3:0] learn_event_i;
  logic [7:0] reg_rdata_o, adv_addr_o, adv_wdata_o, machine_enable_o, machine1_outs_o;
  logic [3:0] adv_page_sel_o;
  logic [15:0] long_count_value_o;
  logic latch_mode_o, adv_wr_o, adv_rd_o, learn_result_batch_en_o, step_count_batch_en_o;
  logic gyro_bias_batch_en_o, gravity_batch_en_o, quaternion_batch_en_o, learn_feature_batch_en_o;
  int mismatches = 0;
  int num_checks = 0;
  int wr_pulses = 0;
  int rd_pulses = 0;
  logic [7:0] offs [10];
  logic [7:0] bsel [5];

  emb_page_regs i_emb_page_regs (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .main_page_i(main_page_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .emb_event_i(emb_event_i),
    .machine_event_i(machine_event_i), .learn_event_i(learn_event_i),
    .long_count_tick_i(long_count_tick_i), .machine1_out_i(machine1_out_i),
    .adv_rdata_i(adv_rdata_i), .latch_mode_o(latch_mode_o), .adv_page_sel_o(adv_page_sel_o),
    .adv_addr_o(adv_addr_o), .adv_wdata_o(adv_wdata_o), .adv_wr_o(adv_wr_o), .adv_rd_o(adv_rd_o),
    .learn_result_batch_en_o(learn_result_batch_en_o), .step_count_batch_en_o(step_count_batch_en_o),
    .gyro_bias_batch_en_o(gyro_bias_batch_en_o), .gravity_batch_en_o(gravity_batch_en_o),
    .quaternion_batch_en_o(quaternion_batch_en_o), .learn_feature_batch_en_o(learn_feature_batch_en_o),
    .machine_enable_o(machine_enable_o), .long_count_value_o(long_count_value_o),
    .machine1_outs_o(machine1_outs_o)
  );

  ////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // Count page strobes mid-cycle, so the count never races the bench's own checks
  always @(negedge sys_clk_i) begin
    if (adv_wr_o === 1'b1) wr_pulses++;
    if (adv_rd_o === 1'b1) rd_pulses++;
  end

  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Every bus task starts and ends just after a rising edge with both strobes low
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle there
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(nm, {8'h00, exp}, {8'h00, reg_rdata_o});
    @(posedge sys_clk_i);
  endtask

  // One-cycle event pulse, dropped before any read follows
  task automatic pulse(input logic [7:0] e, input logic [7:0] m, input logic [3:0] l);
    emb_event_i <= e;
    machine_event_i <= m;
    learn_event_i <= l;
    @(posedge sys_clk_i);
    emb_event_i <= 8'h00;
    machine_event_i <= 8'h00;
    learn_event_i <= 4'h0;
    @(posedge sys_clk_i);
  endtask

  ////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the roughly 130 cycles the sequence needs
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    mismatches++;
    wrap_up();
  end

  initial begin
    offs = '{OFF_PAGE_SELECT, OFF_LEARN_STATUS, OFF_PAGE_ACCESS, OFF_BATCH_A, OFF_BATCH_B,
             OFF_MACHINE_ENABLES, OFF_LONG_COUNT_LOW, OFF_LONG_COUNT_HIGH, OFF_ACK_KEEP_MASK,
             OFF_MACHINE_ONE_OUTS};
    bsel = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h02};
    {rst_n_i, main_page_i, reg_wr_i, reg_rd_i, long_count_tick_i} = 5'b0;
    {reg_addr_i, reg_wdata_i, emb_event_i, machine_event_i, machine1_out_i} = 40'h0;
    learn_event_i = 4'h0;
    adv_rdata_i = 8'h3c;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    // Reset state of the control outputs and of ten registers; 08h, 09h, 12h and 13h are not read
    chk("ctl_reset", 16'h0, {7'h0, latch_mode_o, adv_wr_o, adv_rd_o, learn_result_batch_en_o,
        step_count_batch_en_o, gyro_bias_batch_en_o, gravity_batch_en_o, quaternion_batch_en_o,
        learn_feature_batch_en_o}); // defaults
    chk("enables_reset", 16'h0, {machine_enable_o, machine_enable_o}); // all off
    chk("count_reset", 16'h0, long_count_value_o); // zero
    foreach (offs[i]) rd(offs[i], 8'h00, "reset_value"); // defaults
    rd(8'h7f, 8'h00, "unmapped");

    // Batch selects, one field at a time with only legal bits set
    foreach (bsel[i]) begin
      wr(OFF_BATCH_A, bsel[i]); // reserved kept zero
      chk("batch_a_outs", {11'h0, bsel[i][7:4], bsel[i][1]}, {11'h0, learn_result_batch_en_o,
          step_count_batch_en_o, gyro_bias_batch_en_o, gravity_batch_en_o,
          quaternion_batch_en_o}); // fields
      rd(OFF_BATCH_A, bsel[i], "batch_a"); // readback
    end
    wr(OFF_BATCH_B, 8'h40); // feature batching
    chk("feature_batch", 16'h1, {15'h0, learn_feature_batch_en_o}); // bit 6
    rd(OFF_BATCH_B, 8'h40, "batch_b"); // readback

    // Machine enables, bit n-1 drives machine n
    wr(OFF_MACHINE_ENABLES, 8'h5a);
    chk("machine_en", 16'h005a, {8'h0, machine_enable_o});
    wr(OFF_MACHINE_ENABLES, 8'ha5);
    rd(OFF_MACHINE_ENABLES, 8'ha5, "machine_en_rd");

    // Long counter bytes, then a tick across the 16-bit wrap
    wr(OFF_LONG_COUNT_LOW, 8'h34);
    wr(OFF_LONG_COUNT_HIGH, 8'h12);
    chk("long_count", 16'h1234, long_count_value_o); // byte lanes
    rd(OFF_LONG_COUNT_HIGH, 8'h12, "count_high");
    wr(OFF_LONG_COUNT_LOW, 8'hff);
    wr(OFF_LONG_COUNT_HIGH, 8'hff);
    long_count_tick_i <= 1'b1;
    @(posedge sys_clk_i);
    long_count_tick_i <= 1'b0;
    @(posedge sys_clk_i);
    rd(OFF_LONG_COUNT_LOW, 8'h00, "count_wrap_low"); // live value
    chk("count_wrap", 16'h0000, long_count_value_o); // unsigned wrap

    // Advanced page: refused while disabled, accepted once enabled
    wr(OFF_PAGE_SELECT, 8'h0a);
    chk("page_sel", 16'h000a, {12'h0, adv_page_sel_o});
    rd(OFF_PAGE_SELECT, 8'h0a, "page_sel_rd");
    wr(OFF_ADV_ADDRESS, 8'h55);
    wr(OFF_ADV_DATA, 8'hc3); // refused
    rd(OFF_ADV_DATA, 8'h00, "page_rd_off"); // disabled
    chk("page_pulses_off", 16'h0, 16'(wr_pulses + rd_pulses)); // disabled
    wr(OFF_PAGE_ACCESS, 8'h60); // reserved kept zero
    wr(OFF_ADV_DATA, 8'hc3); // accepted
    chk("page_wdata", 16'h00c3, {8'h0, adv_wdata_o}); // enabled
    rd(OFF_ADV_DATA, 8'h3c, "page_rd_on"); // enabled
    chk("page_pulses_on", 16'h0101, {8'(wr_pulses), 8'(rd_pulses)}); // one each
    chk("page_addr", 16'h0a55, {4'h0, adv_page_sel_o, adv_addr_o}); // target

    // Latched mode: read clears unkept bits, keep mask protects bit 0
    wr(OFF_PAGE_ACCESS, 8'h80);
    chk("latch_mode", 16'h1, {15'h0, latch_mode_o});
    pulse(8'h00, 8'h00, 4'h5);
    rd(OFF_LEARN_STATUS, 8'h05, "learn_latched"); // held after event
    rd(OFF_LEARN_STATUS, 8'h00, "learn_cleared"); // cleared by read
    wr(OFF_ACK_KEEP_MASK, 8'h01);
    pulse(8'hff, 8'hff, 4'h5);
    rd(OFF_LEARN_STATUS, 8'h05, "learn_kept_1");
    main_page_i <= 1'b1;
    rd(OFF_LEARN_MIRROR, 8'h01, "learn_mirror"); // kept bit only
    rd(OFF_MACHINE_MIRROR, 8'hff, "machine_mirror");
    rd(OFF_MACHINE_MIRROR, 8'h01, "machine_mirror_2");
    rd(OFF_EMBEDDED_MIRROR, 8'hb8, "embedded_mirror"); // live bits
    rd(OFF_EMBEDDED_MIRROR, 8'h00, "embedded_mirror_2");
    main_page_i <= 1'b0;

    // Non-latched mode: status follows the event and reads do not clear
    wr(OFF_PAGE_ACCESS, 8'h00);
    learn_event_i <= 4'ha;
    repeat (2) @(posedge sys_clk_i);
    rd(OFF_LEARN_STATUS, 8'h0a, "learn_live");
    rd(OFF_LEARN_STATUS, 8'h0a, "learn_live_2"); // no clear
    learn_event_i <= 4'h0;
    repeat (2) @(posedge sys_clk_i);
    rd(OFF_LEARN_STATUS, 8'h00, "learn_follow"); // follows event

    // Machine one outputs, sampled every cycle
    machine1_out_i <= 8'h96;
    repeat (2) @(posedge sys_clk_i);
    rd(OFF_MACHINE_ONE_OUTS, 8'h96, "machine1_outs"); // bit order
    chk("machine1_port", 16'h0096, {8'h0, machine1_outs_o});
    wrap_up();
  end
endmodule
`default_nettype wire
